// file: logic/sxr_consts.vh
// constants for the synchronous transfer rate control block
`ifndef SXR_CONSTS_VH
`define SXR_CONSTS_VH

// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define SXR_OFF_CTL3 8'h00
`define SXR_OFF_XFER 8'h04
`define SXR_OFF_TEST1 8'h08
`define SXR_OFF_TEST2 8'h0c
`define SXR_OFF_TEST3 8'h10
`define SXR_OFF_STAT 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define SXR_CTL3_F20 7
`define SXR_SCF_HI 6
`define SXR_SCF_LO 4
`define SXR_CCF_HI 2
`define SXR_CCF_LO 0
`define SXR_TP_HI 7
`define SXR_TP_LO 5
`define SXR_OFS_HI 4
`define SXR_OFS_LO 0
`define SXR_TEST3_NEG 7
`define SXR_TEST2_FILT 1
`define SXR_TEST1_DBL 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define SXR_RST_CTL3 8'h00
`define SXR_RST_XFER 8'h00
`define SXR_RST_TEST 8'h00

// ----------------------------------------
// divider codes and timing
// ----------------------------------------
`define SXR_CODE_DIV4 3'h5
`define SXR_SYNC_MAX_MHZ 80
`define SXR_CLK_MHZ 100
`define SXR_RX_MIN_NS 50
`define SXR_RX_MIN_CYC ((`SXR_RX_MIN_NS * `SXR_CLK_MHZ + 999) / 1000)
`define SXR_RX_QUARTER 4

`endif

// file: logic/sxr_divider.v
// programmable clock-enable divider driven by a three-bit factor code
`include "sxr_consts.vh"

module sxr_divider (
	input wire mclk_in,
	input wire rstn_in,
	input wire [2:0] code_in,
	output reg tick_out
);

	reg [3:0] cnt_reg;
	reg [3:0] cnt_next;
	wire [3:0] div_w;

	// ----------------------------------------
	// code to division ratio
	// ----------------------------------------
	function [3:0] ratio;
		input [2:0] code;
		begin
			case (code)
				3'h0: ratio = 4'h3;
				3'h1: ratio = 4'h1;
				3'h2: ratio = 4'h2; // 1.5 rounded up to whole cycles
				3'h3: ratio = 4'h2;
				3'h4: ratio = 4'h3;
				`SXR_CODE_DIV4: ratio = 4'h4;
				default: ratio = 4'h4;
			endcase
		end
	endfunction

	assign div_w = ratio(code_in);

	// count up and emit one tick per divided period
	always @* begin
		if (cnt_reg >= div_w - 4'h1)
			cnt_next = 4'h0;
		else
			cnt_next = cnt_reg + 4'h1;
	end

	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			cnt_reg <= 4'h0;
			tick_out <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_out <= (cnt_next == 4'h0);
		end
	end

endmodule

// file: logic/sxr_rate_ctl.v
// transfer rate control: clock factors, send period and receive overrun check
`include "sxr_consts.vh"

module sxr_rate_ctl (
	input wire mclk_in,
	input wire rstn_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [7:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	input wire script_we_in,
	input wire [7:0] script_dat_in,
	input wire phase_active_in,
	input wire rx_strobe_in,
	input wire tx_req_in,
	output reg tx_strobe_out,
	output reg rx_take_out,
	output reg async_tick_out,
	output reg sync_tick_out,
	output reg fast20_out,
	output reg negation_out,
	output reg doubler_out,
	output reg long_filter_out,
	output reg [4:0] offset_out,
	output reg [2:0] period_code_out
);

	reg [7:0] ctl3_reg;
	reg [7:0] xfer_reg;
	reg [7:0] test1_reg;
	reg [7:0] test2_reg;
	reg [7:0] test3_reg;
	reg [7:0] xfer_act_reg;
	reg [1:0] rx_sync_reg;
	reg [1:0] rx_edge_reg;
	reg phase_q_reg;
	reg [3:0] tx_cnt_reg;
	reg [3:0] tx_cnt_next;
	reg [7:0] rx_gap_reg;
	reg [7:0] rx_gap_next;
	reg err_reg;
	reg [31:0] rd_next;
	wire acc_w;
	wire wr_w;
	wire sync_tick_w;
	wire async_tick_w;
	wire rx_edge_w;
	wire [3:0] tp_w;
	wire [5:0] factor_w;
	wire [1:0] tick_w;
	wire [7:0] stat_w;
	wire rd_stat_w;
	genvar gi;

	// ----------------------------------------
	// constants
	// ----------------------------------------
	// edges spaced fewer sync ticks than this break the quarter-rate ceiling
	// integer copy first, so the threshold can be cut to the gap counter's width
	localparam integer RX_QUARTER = `SXR_RX_QUARTER;
	localparam [7:0] RX_GAP_MIN = RX_QUARTER[7:0] - 8'h01;

	// ----------------------------------------
	// address helper
	// ----------------------------------------
	// one compare shared by the write and status clear paths
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr == off);
		end
	endfunction

	// ----------------------------------------
	// bus access and decode
	// ----------------------------------------
	// a request is taken once; the ack cycle itself is never a second request
	assign acc_w = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	// writes land on the ack edge, while the master still holds address and data
	assign wr_w = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in & wb_sel_in[0];
	// status is cleared on the edge that captures it, so no overrun slips between
	assign rd_stat_w = acc_w & ~wb_we_in & hit(wb_adr_in, `SXR_OFF_STAT);

	// ack one cycle after the request, dropped the cycle after
	always @(posedge mclk_in) begin
		if (!rstn_in)
			wb_ack_out <= 1'b0;
		else
			wb_ack_out <= acc_w;
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	// register writes; script loads win over the host on a collision
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			ctl3_reg <= `SXR_RST_CTL3;
			xfer_reg <= `SXR_RST_XFER;
			test1_reg <= `SXR_RST_TEST;
			test2_reg <= `SXR_RST_TEST;
			test3_reg <= `SXR_RST_TEST;
		end else begin
			if (wr_w && hit(wb_adr_in, `SXR_OFF_CTL3))
				ctl3_reg <= wb_dat_in[7:0];
			if (script_we_in)
				xfer_reg <= script_dat_in;
			else if (wr_w && hit(wb_adr_in, `SXR_OFF_XFER))
				xfer_reg <= wb_dat_in[7:0];
			if (wr_w && hit(wb_adr_in, `SXR_OFF_TEST1))
				test1_reg <= wb_dat_in[7:0];
			if (wr_w && hit(wb_adr_in, `SXR_OFF_TEST2))
				test2_reg <= wb_dat_in[7:0];
			if (wr_w && hit(wb_adr_in, `SXR_OFF_TEST3))
				test3_reg <= wb_dat_in[7:0];
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// status: sticky overrun, live phase, active offset
	assign stat_w = {err_reg, phase_q_reg, 1'b0, xfer_act_reg[`SXR_OFS_HI:`SXR_OFS_LO]};

	// read mux; unmapped words read zero but still acknowledge
	always @* begin
		rd_next = 32'h0000_0000;
		case (wb_adr_in)
			`SXR_OFF_CTL3: rd_next[7:0] = ctl3_reg;
			`SXR_OFF_XFER: rd_next[7:0] = xfer_reg;
			`SXR_OFF_TEST1: rd_next[7:0] = test1_reg;
			`SXR_OFF_TEST2: rd_next[7:0] = test2_reg;
			`SXR_OFF_TEST3: rd_next[7:0] = test3_reg;
			`SXR_OFF_STAT: rd_next[7:0] = stat_w;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	// read data stands from the ack cycle until the next read
	always @(posedge mclk_in) begin
		if (!rstn_in)
			wb_dat_out <= 32'h0000_0000;
		else if (acc_w && !wb_we_in)
			wb_dat_out <= rd_next;
	end

	// ----------------------------------------
	// clock dividers
	// ----------------------------------------
	// slot 1 feeds the synchronous logic, slot 0 the asynchronous logic
	assign factor_w[5:3] = ctl3_reg[`SXR_SCF_HI:`SXR_SCF_LO];
	assign factor_w[2:0] = ctl3_reg[`SXR_CCF_HI:`SXR_CCF_LO];

	// the two dividers run free and are not phase aligned to each other
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_div
			sxr_divider u_div (
				.mclk_in(mclk_in),
				.rstn_in(rstn_in),
				.code_in(factor_w[gi * 3 +: 3]),
				.tick_out(tick_w[gi])
			);
		end
	endgenerate

	assign sync_tick_w = tick_w[1];
	assign async_tick_w = tick_w[0];

	// ----------------------------------------
	// active setup latched per data phase
	// ----------------------------------------
	// period and offset only move while no phase runs, so a transfer never changes pace
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			xfer_act_reg <= `SXR_RST_XFER;
			phase_q_reg <= 1'b0;
		end else begin
			phase_q_reg <= phase_active_in;
			if (!phase_active_in)
				xfer_act_reg <= xfer_reg;
		end
	end

	// ----------------------------------------
	// send pacing
	// ----------------------------------------
	// period in sync ticks is code plus four, fastest four ticks
	assign tp_w = {1'b0, xfer_act_reg[`SXR_TP_HI:`SXR_TP_LO]} + 4'h4;

	// reload only on a tick with the counter empty, so one strobe opens each period
	// a request raised mid-period waits for the counter; there is no early strobe
	always @* begin
		tx_cnt_next = tx_cnt_reg;
		if (sync_tick_w) begin
			if (tx_cnt_reg != 4'h0)
				tx_cnt_next = tx_cnt_reg - 4'h1;
			else if (tx_req_in && phase_active_in)
				tx_cnt_next = tp_w - 4'h1;
		end
	end

	// the strobe leaves on the tick that found the counter empty
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			tx_cnt_reg <= 4'h0;
			tx_strobe_out <= 1'b0;
		end else begin
			tx_cnt_reg <= tx_cnt_next;
			tx_strobe_out <= sync_tick_w & (tx_cnt_reg == 4'h0) & tx_req_in
				& phase_active_in;
		end
	end

	// ----------------------------------------
	// receive capture
	// ----------------------------------------
	// strobe pin passes two flops before any logic looks at it
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			rx_sync_reg <= 2'b00;
			rx_edge_reg <= 2'b00;
		end else begin
			rx_sync_reg <= {rx_sync_reg[0], rx_strobe_in};
			rx_edge_reg <= {rx_edge_reg[0], rx_sync_reg[1]};
		end
	end

	// rising edge of the synchronised strobe; reset level matches the idle pin
	assign rx_edge_w = rx_edge_reg[0] & ~rx_edge_reg[1];

	// gap counts sync ticks; taking at four-tick spacing is the receive ceiling
	always @* begin
		rx_gap_next = rx_gap_reg;
		if (rx_edge_w)
			rx_gap_next = 8'h00;
		else if (sync_tick_w && rx_gap_reg != 8'hff)
			rx_gap_next = rx_gap_reg + 8'h01;
	end

	// receive path ignores the send code entirely
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			rx_gap_reg <= 8'hff;
			rx_take_out <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			rx_gap_reg <= rx_gap_next;
			rx_take_out <= rx_edge_w;
			// sticky overrun: a new one wins over a status read in the same cycle
			if (rx_edge_w && rx_gap_reg < RX_GAP_MIN)
				err_reg <= 1'b1;
			else if (rd_stat_w)
				err_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// registered mode outputs
	// ----------------------------------------
	// mode bits go straight to pins; keeping them consistent is left to software
	// offset and period show the active copy, not the value software last wrote
	always @(posedge mclk_in) begin
		if (!rstn_in) begin
			async_tick_out <= 1'b0;
			sync_tick_out <= 1'b0;
			fast20_out <= 1'b0;
			negation_out <= 1'b0;
			doubler_out <= 1'b0;
			long_filter_out <= 1'b0;
			offset_out <= 5'h00;
			period_code_out <= 3'h0;
		end else begin
			async_tick_out <= async_tick_w;
			sync_tick_out <= sync_tick_w;
			fast20_out <= ctl3_reg[`SXR_CTL3_F20];
			negation_out <= test3_reg[`SXR_TEST3_NEG];
			doubler_out <= test1_reg[`SXR_TEST1_DBL];
			long_filter_out <= test2_reg[`SXR_TEST2_FILT];
			offset_out <= xfer_act_reg[`SXR_OFS_HI:`SXR_OFS_LO];
			period_code_out <= xfer_act_reg[`SXR_TP_HI:`SXR_TP_LO];
		end
	end

endmodule

// file: testbench/sxr_monitor.sv
// concurrent checks on the rate control ports
module sxr_monitor (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire logic [31:0] wb_dat_out,
	input wire logic rx_strobe_in,
	input wire logic rx_take_out,
	input wire logic tx_strobe_out,
	input wire logic phase_active_in,
	input wire logic tx_req_in,
	input wire logic [2:0] period_code_out,
	input wire logic [4:0] offset_out
);
timeunit 1ns;
timeprecision 1ps;
// ----------------
// properties
// ----------------
default clocking @(posedge mclk_in); endclocking
default disable iff (!rstn_in);
AST_ACK: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
	else $error("bus request not acknowledged next cycle");
AST_ACKP: assert property (wb_ack_out |=> !wb_ack_out)
	else $error("ack longer than one cycle");
AST_RDZ: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
	else $error("read data upper bits not zero");
AST_RX: assert property ($rose(rx_strobe_in) |-> ##4 rx_take_out)
	else $error("receive strobe not taken");
AST_RXC: assert property (rx_take_out |-> $past(rx_strobe_in, 4) && !$past(rx_strobe_in, 5))
	else $error("receive take without a strobe rise");
AST_TXPH: assert property (tx_strobe_out |-> $past(phase_active_in) && $past(tx_req_in))
	else $error("send strobe outside a data phase");
AST_TXGAP: assert property (tx_strobe_out |=> (!tx_strobe_out) [*3])
	else $error("send strobes too close");
AST_HOLD: assert property (phase_active_in && $past(phase_active_in) && $past(phase_active_in, 2) |->
	$stable(period_code_out) && $stable(offset_out))
	else $error("setup changed inside a data phase");
endmodule
bind sxr_rate_ctl sxr_monitor MON (.mclk_in, .rstn_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
	.wb_dat_out, .rx_strobe_in, .rx_take_out, .tx_strobe_out, .phase_active_in, .tx_req_in,
	.period_code_out, .offset_out);

// file: testbench/sxr_peer.sv
// far-side peer model that sends receive strobes
module sxr_peer (
	input wire logic mclk_in,
	output logic rx_out
);
timeunit 1ns;
timeprecision 1ps;
initial rx_out = 1'b0;
// ----------------
// strobe burst
// ----------------
// one rise per transfer; caller keeps per at 5 or more cycles for the 50 ns floor
task automatic burst(input int n, input int per);
	repeat (n) begin
		@(posedge mclk_in);
		rx_out <= 1'b1;
		repeat (per / 2) @(posedge mclk_in);
		rx_out <= 1'b0;
		repeat (per - per / 2 - 1) @(posedge mclk_in);
	end
endtask
endmodule

// file: testbench/sxr_rate_ctl_test.sv
// self-checking bench for the transfer rate control block
`include "sxr_consts.vh"
module sxr_rate_ctl_test;
timeunit 1ns;
timeprecision 1ps;
logic mclk_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, swe = 1'b0;
logic phase = 1'b0, txreq = 1'b0, ack, txs, rxt, atk, stk, f20, neg, dbl, lflt, rx;
logic [7:0] adr = 8'h00, sdat = 8'h00;
logic [31:0] dat = 32'h0, rdat, q;
logic [4:0] ofs;
logic [2:0] pcode;
int error_cnt = 0, n_tests = 0, n_tx, n_rx, n_st, n_at;
initial begin
	forever #5 mclk_in = ~mclk_in;
end
sxr_rate_ctl DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
	.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat), .wb_dat_out(rdat),
	.wb_ack_out(ack), .script_we_in(swe), .script_dat_in(sdat), .phase_active_in(phase),
	.rx_strobe_in(rx), .tx_req_in(txreq), .tx_strobe_out(txs), .rx_take_out(rxt),
	.async_tick_out(atk), .sync_tick_out(stk), .fast20_out(f20), .negation_out(neg),
	.doubler_out(dbl), .long_filter_out(lflt), .offset_out(ofs), .period_code_out(pcode));
sxr_peer PEER (.mclk_in(mclk_in), .rx_out(rx));
// ----------------
// tasks
// ----------------
task final_report;
	$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
	if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
	n_tests++;
	if (got !== exp) begin
		error_cnt++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
// one classic cycle; request held until the edge that samples ack
task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
	int i;
	i = 0;
	@(posedge mclk_in);
	{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
	do begin
		@(posedge mclk_in);
		i++;
	end while (ack !== 1'b1 && i < 20);
	r = rdat;
	{cyc, stb} <= 2'b00;
	if (ack !== 1'b1) begin
		error_cnt++;
		final_report;
	end
endtask
// pulse counts over a window; a multiple of the period gives an exact figure
task count(input int c);
	{n_tx, n_rx, n_st, n_at} = '0;
	repeat (c) begin
		@(posedge mclk_in);
		n_tx += txs;
		n_rx += rxt;
		n_st += stk;
		n_at += atk;
	end
endtask
// ----------------
// sequence
// ----------------
initial begin
	repeat (2) @(posedge mclk_in);
	rstn_in <= 1'b1;
	for (int a = 0; a < 5; a++) begin
		bus(1'b0, 8'(a * 4), 8'h00, q);
		chk(q, 32'h0);
	end
	// every value read back; unmapped place reads zero
	for (int v = 0; v < 2; v++) begin
		for (int a = 0; a < 5; a++) begin
			bus(1'b1, 8'(a * 4), v ? 8'h00 : 8'hff, q);
			bus(1'b0, 8'(a * 4), 8'h00, q);
			chk(q, v ? 32'h0 : 32'hff);
		end
		bus(1'b1, 8'h40, 8'hff, q);
		bus(1'b0, 8'h40, 8'h00, q);
		chk(q, 32'h0);
		chk({f20, neg, dbl, lflt}, v ? 4'h0 : 4'hf);
	end
	@(posedge mclk_in);
	{swe, sdat} <= 9'h13c;
	@(posedge mclk_in);
	swe <= 1'b0;
	bus(1'b0, `SXR_OFF_XFER, 8'h00, q);
	chk(q, 32'h3c);
	chk({pcode, ofs}, 8'h3c);
	phase <= 1'b1;
	bus(1'b1, `SXR_OFF_XFER, 8'hc3, q);
	chk({pcode, ofs}, 8'h3c);
	phase <= 1'b0;
	repeat (3) @(posedge mclk_in);
	chk({pcode, ofs}, 8'hc3);
	// divide by four on both factors, then by one and two
	bus(1'b1, `SXR_OFF_CTL3, 8'h55, q);
	repeat (8) @(posedge mclk_in);
	count(400);
	chk(n_st, 100);
	chk(n_at, 100);
	bus(1'b1, `SXR_OFF_CTL3, 8'h12, q);
	repeat (8) @(posedge mclk_in);
	count(400);
	chk(n_st, 400);
	chk(n_at, 200);
	// send spacing is code plus four sync ticks of four cycles each
	bus(1'b1, `SXR_OFF_CTL3, 8'h55, q);
	for (int c = 0; c < 8; c++) begin
		bus(1'b1, `SXR_OFF_XFER, {3'(c), 5'h00}, q);
		@(posedge mclk_in);
		{phase, txreq} <= 2'b11;
		repeat (60) @(posedge mclk_in);
		count((c + 4) * 20);
		chk(n_tx, 5);
		phase <= 1'b0;
	end
	count(100);
	chk(n_tx, 0);
	// fastest receive at one-cycle ticks, then overrun at divide by four
	bus(1'b1, `SXR_OFF_CTL3, 8'h10, q);
	fork
		PEER.burst(4, 5);
		count(30);
	join
	chk(n_rx, 4);
	bus(1'b0, `SXR_OFF_STAT, 8'h00, q);
	chk(q[7], 1'b0);
	bus(1'b1, `SXR_OFF_CTL3, 8'h55, q);
	PEER.burst(3, 5);
	repeat (6) @(posedge mclk_in);
	bus(1'b0, `SXR_OFF_STAT, 8'h00, q);
	chk(q[7], 1'b1);
	bus(1'b0, `SXR_OFF_STAT, 8'h00, q);
	chk(q[7], 1'b0);
	final_report;
end
endmodule
